// *** logic/synth_ctrl_consts.vh ***
`ifndef SYNTH_CTRL_CONSTS_VH
`define SYNTH_CTRL_CONSTS_VH
// ==========================================
// Word and address layout
`define WORD_BITS        24
`define ADDR2_MAIN       2'b00
`define ADDR2_CONFIG     2'b01
`define ADDR2_PUMP       2'b10
`define ADDR3_LOOP       3'b011
// ==========================================
// Main divider word fields
`define FN_LSB           2
`define FN_MSB           12
`define SWALLOW_LSB      13
`define SWALLOW_MSB      15
`define PROG_LSB         16
`define PROG_MSB         19
`define USE_DEFAULT_BIT  23
// ==========================================
// Configuration word fields
`define AUX_ON_BIT       2
`define MAIN_ON_BIT      3
`define POWER_LSB        4
`define POWER_MSB        5
`define SPUR_LSB         11
`define SPUR_MSB         12
`define REF_SEL_BIT      21
`define AUX_SEL_LSB      22
`define AUX_SEL_MSB      23
// ==========================================
// Pump and loop word fields
`define PUMP_LSB         22
`define PUMP_MSB         23
`define OSC_CUR_LSB      3
`define OSC_CUR_MSB      4
`define BW_ON_BIT        19
`define CRIT_LSB         20
`define CRIT_MSB         21
`define DUR_LSB          22
`define DUR_MSB          23
// ==========================================
// Mode codes
`define SPUR_OFF         2'b00
`define SPUR_TRACK       2'b10
`define SPUR_ONCE        2'b11
// ==========================================
// Reset images (documented default bit patterns)
`define MAIN_RESET       24'h00_0000
`define CONFIG_RESET     24'h90_0141
`define PUMP_RESET       24'h09_D68A
`define LOOP_RESET       24'hFD_E863
`endif

// *** logic/synth_control_word_decoder.v ***
// Contract
// - Divide ratio is prescaler times count plus extras
// - Prescaler is eight or six per variant
// - Address 01 loads configuration word
// - Aux select picks default aux frequency
// - Reference select bit reports reference rate
// - Spur field decodes off, track, once
// - Once mode freezes compensation at lock
// - Output power level monotonic zero to three
// - Main and aux enables act independently
// - Chip enable low powers everything down
// - Address 10 loads pump current word
// - Pump field selects 100/200/300/800 uA
// - Address 011 loads loop bandwidth word
// - Duration field sets controller acting time (here only passed out; bandwidth_active_out has no time limit)
// - Controller stops once phase within criterion
// - Criterion code 00 largest offset allowed
// - Bandwidth enable gates controller while locking
// - Oscillator current scales monotonic with code
// - Shift 24 bits msb first, rising clock
// - Latch strobe rising edge copies shift register
// - Address 00 loads main divider word
`timescale 1ns/1ps
`include "synth_ctrl_consts.vh"
module synth_control_word_decoder #(
    parameter PRESCALER = 8
) (
    input  wire        core_clk_in,
    input  wire        srst_in,
    input  wire        serial_data_in,
    input  wire        serial_clk_in,
    input  wire        latch_strobe_in,
    input  wire        chip_enable_in,
    input  wire        loop_locked_in,
    input  wire        phase_in_criterion_in,
    output reg  [7:0]  main_divide_int_out,
    output reg  [10:0] fractional_numerator_out,
    output reg         use_default_counts_out,
    output reg  [1:0]  aux_default_select_out,
    output reg         reference_rate_select_out,
    output reg  [1:0]  spur_reduction_mode_out,
    output reg         compensation_track_out,
    output reg  [1:0]  output_power_level_out,
    output reg         main_synth_on_out,
    output reg         aux_loop_on_out,
    output reg  [1:0]  aux_pump_current_out,
    output reg  [9:0]  aux_pump_ua_out,
    output reg  [1:0]  bandwidth_duration_out,
    output reg  [1:0]  phase_criterion_out,
    output reg         bandwidth_control_on_out,
    output reg         bandwidth_active_out,
    output reg  [1:0]  oscillator_current_out
);
    // ==========================================
    // Pin synchronisers
    reg [2:0] sclk_sync;
    reg [2:0] latch_sync;
    reg [1:0] data_sync;
    reg [1:0] ce_sync;
    reg [1:0] lock_sync;
    reg [1:0] phase_sync;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            sclk_sync  <= 3'b000;
            latch_sync <= 3'b000;
            data_sync  <= 2'b00;
            ce_sync    <= 2'b00;
            lock_sync  <= 2'b00;
            phase_sync <= 2'b00;
        end else begin
            sclk_sync  <= {sclk_sync[1:0], serial_clk_in};
            latch_sync <= {latch_sync[1:0], latch_strobe_in};
            data_sync  <= {data_sync[0], serial_data_in};
            ce_sync    <= {ce_sync[0], chip_enable_in};
            lock_sync  <= {lock_sync[0], loop_locked_in};
            phase_sync <= {phase_sync[0], phase_in_criterion_in};
        end
    end
    // Edges judged only on stages two and three
    wire sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
    wire latch_rise = latch_sync[1] & ~latch_sync[2];
    wire chip_on    = ce_sync[1];
    wire locked     = lock_sync[1];

    // ==========================================
    // Shift register and word store
    reg [23:0] shift_word;
    reg [23:0] main_word;
    reg [23:0] config_word;
    reg [23:0] pump_word;
    reg [23:0] loop_word;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            shift_word  <= 24'h00_0000;
            main_word   <= `MAIN_RESET;
            config_word <= `CONFIG_RESET;
            pump_word   <= `PUMP_RESET;
            loop_word   <= `LOOP_RESET;
        end else begin
            if (sclk_rise)
                shift_word <= {shift_word[22:0], data_sync[1]};
            // Data lands within three core cycles of clock edge; strobe trails the last rising clock edge by 92.5 ns anyway
            if (latch_rise) begin
                if (shift_word[1:0] == `ADDR2_MAIN)
                    main_word <= shift_word;
                else if (shift_word[1:0] == `ADDR2_CONFIG)
                    config_word <= shift_word;
                else if (shift_word[1:0] == `ADDR2_PUMP)
                    pump_word <= shift_word;
                else if (shift_word[2:0] == `ADDR3_LOOP)
                    loop_word <= shift_word;
                // Longer addresses (aux divider, test) are dropped here
            end
        end
    end

    // ==========================================
    // Field decode
    wire [3:0]  prog_cnt    = main_word[`PROG_MSB:`PROG_LSB];
    wire [2:0]  swallow_cnt = main_word[`SWALLOW_MSB:`SWALLOW_LSB];
    wire [7:0]  prescale_w  = PRESCALER[7:0];
    // Range of counts is the host's duty; no clamping
    wire [7:0]  next_divide = prescale_w * {4'h0, prog_cnt} + {5'h00, swallow_cnt};
    wire [1:0]  spur_mode   = config_word[`SPUR_MSB:`SPUR_LSB];
    wire [1:0]  pump_code   = pump_word[`PUMP_MSB:`PUMP_LSB];
    reg  [9:0]  next_pump_ua;
    always @* begin
        case (pump_code)
            2'b00:   next_pump_ua = 10'd100;
            2'b01:   next_pump_ua = 10'd200;
            2'b10:   next_pump_ua = 10'd300;
            default: next_pump_ua = 10'd800;
        endcase
    end

    // ==========================================
    // Compensation tracking and bandwidth controller
    reg locked_d;
    reg frozen;
    wire lock_rise = locked & ~locked_d;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            locked_d <= 1'b0;
            frozen   <= 1'b0;
        end else begin
            locked_d <= locked;
            // Freeze only at the entry to lock; leaving lock rearms
            if (spur_mode != `SPUR_ONCE || !locked)
                frozen <= 1'b0;
            else if (lock_rise)
                frozen <= 1'b1;
        end
    end

    // ==========================================
    // Output registers
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            main_divide_int_out       <= 8'h00;
            fractional_numerator_out  <= 11'h000;
            use_default_counts_out    <= 1'b0;
            aux_default_select_out    <= 2'b00;
            reference_rate_select_out <= 1'b0;
            spur_reduction_mode_out   <= 2'b00;
            compensation_track_out    <= 1'b0;
            output_power_level_out    <= 2'b00;
            main_synth_on_out         <= 1'b0;
            aux_loop_on_out           <= 1'b0;
            aux_pump_current_out      <= 2'b00;
            aux_pump_ua_out           <= 10'h000;
            bandwidth_duration_out    <= 2'b00;
            phase_criterion_out       <= 2'b00;
            bandwidth_control_on_out  <= 1'b0;
            bandwidth_active_out      <= 1'b0;
            oscillator_current_out    <= 2'b00;
        end else begin
            main_divide_int_out       <= next_divide;
            fractional_numerator_out  <= main_word[`FN_MSB:`FN_LSB];
            use_default_counts_out    <= main_word[`USE_DEFAULT_BIT];
            aux_default_select_out    <= config_word[`AUX_SEL_MSB:`AUX_SEL_LSB];
            reference_rate_select_out <= config_word[`REF_SEL_BIT];
            spur_reduction_mode_out   <= spur_mode;
            // Code 01 unused; treated as off
            compensation_track_out    <= chip_on &&
                                         (spur_mode == `SPUR_TRACK ||
                                          (spur_mode == `SPUR_ONCE && !frozen && !locked));
            output_power_level_out    <= config_word[`POWER_MSB:`POWER_LSB];
            main_synth_on_out         <= chip_on & config_word[`MAIN_ON_BIT];
            aux_loop_on_out           <= chip_on & config_word[`AUX_ON_BIT];
            aux_pump_current_out      <= pump_code;
            aux_pump_ua_out           <= next_pump_ua;
            bandwidth_duration_out    <= loop_word[`DUR_MSB:`DUR_LSB];
            phase_criterion_out       <= loop_word[`CRIT_MSB:`CRIT_LSB];
            bandwidth_control_on_out  <= loop_word[`BW_ON_BIT];
            // Acts while locking, stops once phase is inside criterion
            bandwidth_active_out      <= chip_on & config_word[`MAIN_ON_BIT] & loop_word[`BW_ON_BIT]
                                         & ~locked & ~phase_sync[1];
            oscillator_current_out    <= loop_word[`OSC_CUR_MSB:`OSC_CUR_LSB];
        end
    end
endmodule // synth_control_word_decoder

// *** tb/host_link_model.sv ***
`timescale 1ns/1ps
// ====================
// Host side of the serial link
module host_link_model (
    output logic serial_data_out,
    output logic serial_clk_out,
    output logic latch_strobe_out
);
    initial begin
        serial_data_out = 1'b0;
        serial_clk_out = 1'b0;
        latch_strobe_out = 1'b0;
    end
    // Link clock parked low between frames, 125 ns period inside
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data_out = w[i];
            #62.5 serial_clk_out = 1'b1;
            #62.5 serial_clk_out = 1'b0;
        end
        #30 latch_strobe_out = 1'b1;
        #60 latch_strobe_out = 1'b0;
        // Released line shows the inverse, never a stale bit
        serial_data_out = ~w[0];
        #40;
    endtask
endmodule // host_link_model

// *** tb/synth_control_word_decoder_asserts.sv ***
`timescale 1ns/1ps
// ====================
// Port checker
module synth_control_word_decoder_asserts (
    input wire logic       core_clk_in,
    input wire logic       srst_in,
    input wire logic       latch_strobe_in,
    input wire logic       chip_enable_in,
    input wire logic       loop_locked_in,
    input wire logic       phase_in_criterion_in,
    input wire logic [1:0] aux_default_select_out,
    input wire logic [1:0] spur_reduction_mode_out,
    input wire logic       compensation_track_out,
    input wire logic       main_synth_on_out,
    input wire logic       aux_loop_on_out,
    input wire logic [1:0] aux_pump_current_out,
    input wire logic [9:0] aux_pump_ua_out,
    input wire logic       bandwidth_control_on_out,
    input wire logic       bandwidth_active_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // Five samples cover the pin synchroniser
    sequence ce_off_s; (!chip_enable_in) [*5]; endsequence
    sequence once_locked_s; (spur_reduction_mode_out == 2'b11 && loop_locked_in && chip_enable_in) [*5]; endsequence
    sequence tracking_s; (spur_reduction_mode_out == 2'b10 && chip_enable_in) [*5]; endsequence
    chk_power_down_all: assert property (ce_off_s |-> !main_synth_on_out && !aux_loop_on_out
        && !compensation_track_out && !bandwidth_active_out) else $error("active while chip disabled");
    chk_once_frozen: assert property (once_locked_s |-> !compensation_track_out)
        else $error("compensation moves after lock in once mode");
    chk_track_running: assert property (tracking_s |-> compensation_track_out)
        else $error("tracking mode not adjusting");
    chk_spur_off: assert property ((spur_reduction_mode_out == 2'b00) [*5] |-> !compensation_track_out)
        else $error("compensation adjusting with reduction off");
    chk_bw_disabled: assert property ((!bandwidth_control_on_out) [*3] |-> !bandwidth_active_out)
        else $error("bandwidth control acts while disabled");
    chk_bw_criterion_stop: assert property (phase_in_criterion_in [*5] |-> !bandwidth_active_out)
        else $error("bandwidth control acts within criterion");
    chk_pump_table: assert property ($stable(aux_pump_current_out) && aux_pump_ua_out != 10'h000 |->
        aux_pump_ua_out == (aux_pump_current_out[1] ? (aux_pump_current_out[0] ? 10'h320 : 10'h12c)
        : (aux_pump_current_out[0] ? 10'h0c8 : 10'h064))) else $error("pump current code and value disagree");
    chk_config_hold: assert property ((!latch_strobe_in && !srst_in) [*8] |-> $stable(aux_default_select_out)
        && $stable(spur_reduction_mode_out)) else $error("configuration changed without strobe");
endmodule // synth_control_word_decoder_asserts
bind synth_control_word_decoder synth_control_word_decoder_asserts i_chk (.core_clk_in, .srst_in,
    .latch_strobe_in, .chip_enable_in, .loop_locked_in, .phase_in_criterion_in, .aux_default_select_out,
    .spur_reduction_mode_out, .compensation_track_out, .main_synth_on_out, .aux_loop_on_out,
    .aux_pump_current_out, .aux_pump_ua_out, .bandwidth_control_on_out, .bandwidth_active_out);

// *** tb/synth_control_word_decoder_tb.sv ***
`timescale 1ns/1ps
`include "synth_ctrl_consts.vh"
// ====================
// Bench
module synth_control_word_decoder_tb;
    localparam int PRESC = 8;
    logic core_clk_in = 1'b0, srst_in = 1'b1, ce = 1'b1, lock = 1'b0, crit = 1'b0;
    wire sd, sc, le, udc, rsel, ctrk, pon, aon, bwon, bwact;
    wire [7:0] div;
    wire [10:0] fn;
    wire [1:0] asel, spur, pwr, pump, dur, pcrit, osc;
    wire [9:0] ua;
    logic [23:0] mw, cw, pw, lw, w;
    int n_mismatch = 0, compares = 0;
    always #5 core_clk_in = ~core_clk_in;
    host_link_model i_host (.serial_data_out(sd), .serial_clk_out(sc), .latch_strobe_out(le));
    synth_control_word_decoder #(.PRESCALER(PRESC)) i_dut (.core_clk_in, .srst_in, .serial_data_in(sd),
        .serial_clk_in(sc), .latch_strobe_in(le), .chip_enable_in(ce), .loop_locked_in(lock),
        .phase_in_criterion_in(crit), .main_divide_int_out(div), .fractional_numerator_out(fn),
        .use_default_counts_out(udc), .aux_default_select_out(asel), .reference_rate_select_out(rsel),
        .spur_reduction_mode_out(spur), .compensation_track_out(ctrk), .output_power_level_out(pwr),
        .main_synth_on_out(pon), .aux_loop_on_out(aon), .aux_pump_current_out(pump), .aux_pump_ua_out(ua),
        .bandwidth_duration_out(dur), .phase_criterion_out(pcrit), .bandwidth_control_on_out(bwon),
        .bandwidth_active_out(bwact), .oscillator_current_out(osc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset;
        srst_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        {mw, cw, pw, lw} = {`MAIN_RESET, `CONFIG_RESET, `PUMP_RESET, `LOOP_RESET};
        // Pin synchronisers refill before outputs settle
        repeat (5) @(posedge core_clk_in);
    endtask
    task automatic check_all;
        logic [9:0] ua_exp;
        ua_exp = pw[23] ? (pw[22] ? 10'h320 : 10'h12c) : (pw[22] ? 10'h0c8 : 10'h064);
        check(div, PRESC * mw[19:16] + mw[15:13]);
        check({udc, fn}, {mw[23], mw[12:2]});
        check({asel, rsel, spur, pwr}, {cw[23:21], cw[12:11], cw[5:4]});
        check({pon, aon, ctrk}, {ce & cw[3], ce & cw[2],
            ce & (cw[12:11] == 2'b10 | cw[12:11] == 2'b11 & !lock)});
        check({pump, ua}, {pw[23:22], ua_exp});
        check({dur, pcrit, bwon, osc}, {lw[23:19], lw[4:3]});
        check(bwact, ce & cw[3] & lw[19] & !lock & !crit);
    endtask
    initial begin
        void'($urandom(32'h3530_b0de));
        do_reset;
        check_all;
        // Address cycles through all four words and one unmapped code
        for (int n = 0; n < 40; n++) begin
            if (n == 30) begin
                do_reset;
                check_all;
            end
            w = $urandom;
            case (n % 5)
                0: begin
                    w[19:16] = $urandom_range(15, 2);
                    w[15:13] = $urandom_range(w[19:16] > 7 ? 7 : w[19:16] - 1);
                    w[12:0] = {11'($urandom_range(1919)), 2'b00};
                end
                1: {w[12:11], w[1:0]} = {2'(n / 5), 2'b01};
                2: {w[23:22], w[1:0]} = {2'(n / 5), 2'b10};
                3: w[2:0] = 3'b011;
                default: w[2:0] = 3'b111;
            endcase
            ce <= ($urandom_range(3) != 0);
            lock <= $urandom_range(1);
            crit <= $urandom_range(1);
            i_host.send_word(w);
            case (n % 5)
                0: mw = w;
                1: cw = w;
                2: pw = w;
                3: lw = w;
                default: ;
            endcase
            repeat (4) @(posedge core_clk_in);
            check_all;
        end
        tally_and_finish;
    end
    // Forty frames of about 3.2 us each
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // synth_control_word_decoder_tb
